/* core/tdo_core.sv */
// detection and output logic of a single-channel touch sensor.
// assumes a front end that measures one burst per request and returns a 16-bit count;
// reset is asserted only at power-up; recalibration follows power-up and a max-duration timeout.
`timescale 1ns/1ps

// Notes on behaviour
// RULE_01: signal, reference and threshold arithmetic is 16 bits wide.
// RULE_02: reference steps toward the raw signal by a limited amount; levels follow it.
// RULE_03: reference tracking is frozen while a detection is in effect.
// RULE_04: falling signals are tracked with a larger step than rising ones.
// RULE_05: threshold is reference plus a delta proportional to the signal, recomputed continuously.
// RULE_06: detection ends when signal drops below reference plus half the delta.
// RULE_07: a detection lasting past the maximum duration forces a full recalibration.
// RULE_08: two straps select level 10s, level 60s, toggle or pulse mode.
// RULE_09: integrator counts detecting bursts, confirms at four, clears on any miss.
// RULE_10: bursts every 75ms when idle, 18ms apart while confirming.
// RULE_11: no recalibration input; only power-up and a max-duration timeout force one.
// RULE_12: straps are read only once, right after power-up.
// RULE_13: level mode output follows detection; timeout makes it inactive until next.
// RULE_14: toggle mode inverts a latched output on each new confirmed detection.
// RULE_15: toggle mode uses 10s and keeps the latched state across a timeout.
// RULE_16: pulse mode emits one 75ms active pulse per new confirmed detection.
// RULE_17: pulse mode uses a fixed 10s maximum duration.
// RULE_18: output goes high impedance for 350us before every burst.
// RULE_19: a build parameter selects active-high or active-low output.
// RULE_20: three gain levels from the gain strap, open means high gain.
// RULE_21: recalibration loads reference from signal, clears integrator, ends detection.
module tdo_core
  import tdo_pkg::*;
#(
  parameter bit          ACTIVE_HIGH       = 1'b0,
  parameter int unsigned BURST_IDLE_CYC    = CYC_BURST_IDLE,
  parameter int unsigned BURST_FAST_CYC    = CYC_BURST_FAST,
  parameter int unsigned GAP_CYC           = CYC_GAP,
  parameter int unsigned PULSE_CYC         = CYC_PULSE,
  parameter int unsigned TICK_CYC          = CYC_TICK,
  parameter int unsigned MAXON_SHORT_TICKS = TICKS_MAXON_SHORT,
  parameter int unsigned MAXON_LONG_TICKS  = TICKS_MAXON_LONG
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             mode_strap_a_i,
  input  wire logic             mode_strap_b_i,
  input  wire logic [1:0]       gain_sel_i,
  input  wire logic             raw_valid_i,
  input  wire logic [SIG_W-1:0] raw_i,
  output logic                  burst_req_o,
  output logic                  out_o,
  output logic                  out_oe_o,
  output logic                  health_gap_pulse_o,
  output logic                  detect_o
);

  // sequencer: strap capture once, then health gap, burst and wait in a loop
  typedef enum logic [3:0] {
    ST_STRAP = 4'b0001,
    ST_WAIT  = 4'b0010,
    ST_GAP   = 4'b0100,
    ST_BURST = 4'b1000
  } tdo_state_t;

  tdo_state_t         st_reg;
  tdo_state_t         st_next;
  tdo_cfg_t           cfg_reg;
  tdo_cfg_t           cfg_next;
  logic [SIG_W-1:0]   ref_reg; // see RULE_01
  logic [SIG_W-1:0]   ref_next;
  logic [INTEG_W-1:0] integ_reg;
  logic [INTEG_W-1:0] integ_next;
  logic               det_reg;
  logic               det_next;
  logic               tog_reg;
  logic               tog_next;
  logic               recal_reg;
  logic               recal_next;
  logic [TICK_W-1:0]  tick_cnt_reg;
  logic [TICK_W-1:0]  tick_cnt_next;
  logic               req_reg;
  logic               req_next;
  logic               out_reg;
  logic               out_next;
  logic               oe_reg;
  logic               oe_next;
  logic               gap_reg;
  logic               gap_next;

  logic               ph_load;
  logic [TMR_W-1:0]   ph_val;
  logic               ph_done;
  logic               pl_load;
  logic               pl_busy;
  logic               tick_load;
  logic               tick_done;
  tdo_levels_t        levels;
  logic [SIG_W-1:0]   diff;
  logic [TICK_W-1:0]  maxon_lim;
  logic               fast;
  logic               active;

  // burst spacing and health gap share one timer: they never overlap
  tdo_down_timer #(.W(TMR_W)) u_phase (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .load_i     (ph_load),
    .load_val_i (ph_val),
    .busy_o     (),
    .done_o     (ph_done)
  );

  // pulse width timer, loaded only on a confirmed detection in pulse mode
  tdo_down_timer #(.W(TMR_W)) u_pulse (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .load_i     (pl_load),
    .load_val_i (TMR_W'(PULSE_CYC)),
    .busy_o     (pl_busy),
    .done_o     ()
  );

  // max-on prescaler: one tick per TICK_CYC cycles of detection
  tdo_down_timer #(.W(TMR_W)) u_tick (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .load_i     (tick_load),
    .load_val_i (TMR_W'(TICK_CYC)),
    .busy_o     (),
    .done_o     (tick_done)
  );

  // levels use the live result, so each compare sees this burst's own delta
  tdo_level_calc u_levels (
    .ref_i    (ref_reg),
    .raw_i    (raw_i),
    .gain_i   (cfg_reg.gain),
    .levels_o (levels)
  ); // see RULE_05, see RULE_20

  // toggle and pulse are always short; only level mode honours the long strap
  assign maxon_lim = (cfg_reg.mode == MODE_LEVEL && cfg_reg.long_to) ?
                     TICK_W'(MAXON_LONG_TICKS) : TICK_W'(MAXON_SHORT_TICKS); // see RULE_15, see RULE_17
  // prescaler only runs while a detection is in effect
  assign tick_load = !det_reg || tick_done;

  always_comb begin
    // strobes default low; state holds unless a branch below moves it
    st_next       = st_reg;
    cfg_next      = cfg_reg;
    ref_next      = ref_reg;
    integ_next    = integ_reg;
    det_next      = det_reg;
    tog_next      = tog_reg;
    recal_next    = recal_reg;
    tick_cnt_next = tick_cnt_reg;
    req_next      = 1'b0;
    ph_load       = 1'b0;
    ph_val        = '0;
    pl_load       = 1'b0;
    diff          = '0;
    fast          = 1'b0;

    unique case (st_reg)
      ST_STRAP: begin
        // straps are caught once after power-up and never again
        unique case ({mode_strap_a_i, mode_strap_b_i})
          2'b11:   cfg_next.mode = MODE_LEVEL;
          2'b10:   cfg_next.mode = MODE_LEVEL;
          2'b00:   cfg_next.mode = MODE_TOGGLE;
          default: cfg_next.mode = MODE_PULSE;
        endcase // see RULE_08, see RULE_12
        cfg_next.long_to = mode_strap_a_i && !mode_strap_b_i; // see RULE_08
        cfg_next.gain    = gain_sel_i; // see RULE_20
        recal_next       = 1'b1; // see RULE_11
        ph_load          = 1'b1;
        ph_val           = TMR_W'(GAP_CYC);
        st_next          = ST_GAP;
      end
      ST_WAIT: begin
        if (ph_done) begin
          ph_load = 1'b1;
          ph_val  = TMR_W'(GAP_CYC);
          st_next = ST_GAP;
        end
      end
      ST_GAP: begin
        if (ph_done) begin
          req_next = 1'b1;
          st_next  = ST_BURST;
        end
      end
      ST_BURST: begin
        req_next = 1'b1;
        if (raw_valid_i) begin
          req_next = 1'b0;
          // first result after power-up or a timeout becomes the new reference
          if (recal_reg) begin
            ref_next   = raw_i; // see RULE_21
            integ_next = '0;
            det_next   = 1'b0;
            recal_next = 1'b0;
            // reference is left alone while a detection is in effect
          end else if (det_reg) begin // see RULE_03
            if (raw_i < levels.drop) begin
              det_next   = 1'b0; // see RULE_06
              integ_next = '0;
            end
          end else if (raw_i > levels.thr) begin
            integ_next = integ_reg + INTEG_W'(1); // see RULE_09
            if (integ_next == INTEG_LIMIT) begin
              det_next   = 1'b1;
              integ_next = '0;
              tog_next   = (cfg_reg.mode == MODE_TOGGLE) ? !tog_reg : tog_reg; // see RULE_14
              pl_load    = (cfg_reg.mode == MODE_PULSE); // see RULE_16
            end
          end else begin
            integ_next = '0; // see RULE_09
            // tracking runs only with no detection and no count pending
            if (integ_reg == '0) begin
              if (raw_i > ref_reg) begin
                diff     = raw_i - ref_reg;
                ref_next = ref_reg + ((diff > DRIFT_UP_STEP) ? DRIFT_UP_STEP : diff); // see RULE_02, see RULE_04
              end else begin
                diff     = ref_reg - raw_i;
                ref_next = ref_reg - ((diff > DRIFT_DN_STEP) ? DRIFT_DN_STEP : diff); // see RULE_02, see RULE_04
              end
            end
          end
          // the next wait is shortened while a confirmation is pending
          fast    = (integ_next != '0) && !det_next; // see RULE_10
          ph_load = 1'b1;
          ph_val  = fast ? TMR_W'(BURST_FAST_CYC - GAP_CYC) : TMR_W'(BURST_IDLE_CYC - GAP_CYC); // see RULE_10
          st_next = ST_WAIT;
        end
      end
    endcase

    // max on-duration: a timeout overrides whatever the burst result said
    // limitation: the count starts at the confirming edge, not at the first hit
    if (!det_reg) begin
      tick_cnt_next = '0;
    end else if (tick_done) begin
      if (tick_cnt_reg + TICK_W'(1) >= maxon_lim) begin
        det_next      = 1'b0; // see RULE_07, see RULE_13
        integ_next    = '0;
        recal_next    = 1'b1; // see RULE_21
        tick_cnt_next = '0;
      end else begin
        tick_cnt_next = tick_cnt_reg + TICK_W'(1);
      end
    end
  end

  // the toggle latch is not touched by a timeout, so its state survives recalibration
  always_comb begin
    unique case (cfg_reg.mode)
      MODE_TOGGLE: active = tog_reg; // see RULE_15
      MODE_PULSE:  active = pl_busy;
      default:     active = det_reg; // see RULE_13
    endcase
    out_next = ACTIVE_HIGH ? active : !active; // see RULE_19
    gap_next = (st_next == ST_GAP); // see RULE_18
    oe_next  = !gap_next; // see RULE_18
  end

  // outputs are registered so the pin never shows a decode glitch
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg       <= ST_STRAP;
      cfg_reg      <= CFG_RESET;
      ref_reg      <= REF_RESET;
      integ_reg    <= '0;
      det_reg      <= 1'b0;
      tog_reg      <= 1'b0;
      recal_reg    <= 1'b1;
      tick_cnt_reg <= '0;
      req_reg      <= 1'b0;
      out_reg      <= !ACTIVE_HIGH;
      oe_reg       <= 1'b1;
      gap_reg      <= 1'b0;
    end else begin
      st_reg       <= st_next;
      cfg_reg      <= cfg_next;
      ref_reg      <= ref_next;
      integ_reg    <= integ_next;
      det_reg      <= det_next;
      tog_reg      <= tog_next;
      recal_reg    <= recal_next;
      tick_cnt_reg <= tick_cnt_next;
      req_reg      <= req_next;
      out_reg      <= out_next;
      oe_reg       <= oe_next;
      gap_reg      <= gap_next;
    end
  end

  assign burst_req_o        = req_reg;
  assign out_o              = out_reg;
  assign out_oe_o           = oe_reg;
  assign health_gap_pulse_o = gap_reg;
  assign detect_o           = det_reg;

endmodule : tdo_core

/* core/tdo_pkg.sv */
// package of the touch detect output logic: widths, timing figures, strap codes, types.
// assumes a 200 MHz core clock; long counts are overridable as top-level parameters.
package tdo_pkg;

  localparam int SIG_W          = 16;
  localparam int CLK_MHZ        = 200;

  // timing figures as specified, then derived cycle counts
  localparam int T_BURST_IDLE_US = 75000;
  localparam int T_BURST_FAST_US = 18000;
  localparam int T_GAP_NS        = 350000;
  localparam int T_PULSE_US      = 75000;
  localparam int T_MAXON_SHORT_S = 10;
  localparam int T_MAXON_LONG_S  = 60;
  localparam int T_TICK_US       = 1000;

  localparam int CYC_BURST_IDLE  = T_BURST_IDLE_US * CLK_MHZ;
  localparam int CYC_BURST_FAST  = T_BURST_FAST_US * CLK_MHZ;
  localparam int CYC_GAP         = (T_GAP_NS * CLK_MHZ + 999) / 1000;
  localparam int CYC_PULSE       = T_PULSE_US * CLK_MHZ;
  localparam int CYC_TICK        = T_TICK_US * CLK_MHZ;
  localparam int TICKS_MAXON_SHORT = T_MAXON_SHORT_S * 1000000 / T_TICK_US;
  localparam int TICKS_MAXON_LONG  = T_MAXON_LONG_S * 1000000 / T_TICK_US;

  localparam int TMR_W   = 32;
  localparam int TICK_W  = 16;
  localparam int INTEG_W = 3;
  localparam logic [INTEG_W-1:0] INTEG_LIMIT = 3'h4;

  // drift steps per burst, falling signal tracked faster
  localparam logic [SIG_W-1:0] DRIFT_UP_STEP = 16'h0001;
  localparam logic [SIG_W-1:0] DRIFT_DN_STEP = 16'h0008;
  localparam logic [SIG_W-1:0] REF_RESET     = 16'h0000;

  // gain strap codes and the shift that sets delta = signal >> shift
  localparam logic [1:0] GAIN_OPEN = 2'h0;
  localparam logic [1:0] GAIN_MED  = 2'h1;
  localparam logic [1:0] GAIN_LOW  = 2'h2;
  localparam int GAIN_SHIFT_HIGH = 5;
  localparam int GAIN_SHIFT_MED  = 4;
  localparam int GAIN_SHIFT_LOW  = 3;

  typedef enum logic [2:0] {
    MODE_LEVEL  = 3'b001,
    MODE_TOGGLE = 3'b010,
    MODE_PULSE  = 3'b100
  } tdo_mode_t;

  typedef struct packed {
    tdo_mode_t  mode;
    logic       long_to;
    logic [1:0] gain;
  } tdo_cfg_t;

  localparam tdo_cfg_t CFG_RESET = '{mode: MODE_LEVEL, long_to: 1'b0, gain: GAIN_OPEN};

  typedef struct packed {
    logic [SIG_W-1:0] thr;
    logic [SIG_W-1:0] drop;
  } tdo_levels_t;

endpackage : tdo_pkg

/* core/tdo_down_timer.sv */
// loadable down-counter used for burst spacing, health gap, output pulse and tick prescale.
// assumes load and count share one clock; a load overrides counting.
`timescale 1ns/1ps
module tdo_down_timer
  import tdo_pkg::*;
#(
  parameter int W = TMR_W
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  output logic              busy_o,
  output logic              done_o
);

  logic [W-1:0] count_reg;
  logic [W-1:0] count_next;

  always_comb begin
    count_next = count_reg;
    if (load_i) begin
      count_next = load_val_i;
    end else if (count_reg != '0) begin
      count_next = count_reg - W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      count_reg <= '0;
    end else begin
      count_reg <= count_next;
    end
  end

  assign busy_o = (count_reg != '0);
  // one-cycle mark on the last counted cycle; left ungated by load_i so a user
  // may reload on the mark without closing a combinational loop
  assign done_o = (count_reg == W'(1));

endmodule : tdo_down_timer

/* core/tdo_level_calc.sv */
// threshold and drop-out levels from the reference, the raw signal and the gain strap.
// assumes unsigned 16-bit values; sums saturate rather than wrap.
`timescale 1ns/1ps
module tdo_level_calc
  import tdo_pkg::*;
(
  input  wire logic [SIG_W-1:0] ref_i,
  input  wire logic [SIG_W-1:0] raw_i,
  input  wire logic [1:0]       gain_i,
  output tdo_levels_t           levels_o
);

  logic [SIG_W-1:0] delta;
  logic [SIG_W:0]   thr_sum;
  logic [SIG_W:0]   drop_sum;

  always_comb begin
    unique case (gain_i)
      GAIN_MED: delta = raw_i >> GAIN_SHIFT_MED;
      GAIN_LOW: delta = raw_i >> GAIN_SHIFT_LOW;
      default:  delta = raw_i >> GAIN_SHIFT_HIGH;
    endcase
    // delta scales with the absolute signal, so sensitivity holds as the front end drifts
    thr_sum  = {1'b0, ref_i} + {1'b0, delta};
    drop_sum = {1'b0, ref_i} + {2'b00, delta[SIG_W-1:1]};
    levels_o.thr  = thr_sum[SIG_W] ? '1 : thr_sum[SIG_W-1:0];
    levels_o.drop = drop_sum[SIG_W] ? '1 : drop_sum[SIG_W-1:0];
  end

endmodule : tdo_level_calc

/* bench/tdo_core_monitor.sv */
// checker for tdo_core: health gap, burst handshake, detection cause, max-on bound, level output.
// assumes it is bound into tdo_core and sees only that module's ports.
`timescale 1ns/1ps
module tdo_core_monitor
  import tdo_pkg::*;
#(
  parameter bit          ACTIVE_HIGH      = 1'b0,
  parameter int unsigned GAP_CYC          = CYC_GAP,
  parameter int unsigned TICK_CYC         = CYC_TICK,
  parameter int unsigned MAXON_LONG_TICKS = TICKS_MAXON_LONG
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic mode_strap_a_i,
  input wire logic raw_valid_i,
  input wire logic burst_req_o,
  input wire logic out_o,
  input wire logic out_oe_o,
  input wire logic health_gap_pulse_o,
  input wire logic detect_o
);
  logic [31:0] gap_cnt_reg;
  logic [31:0] on_cnt_reg;
  logic        rst_q_reg;
  logic        lvl_reg;
  wire         take = burst_req_o && raw_valid_i;

  always_ff @(posedge clk_i) begin
    rst_q_reg   <= rst_n_i;
    gap_cnt_reg <= (!rst_n_i || out_oe_o) ? 32'h0000_0000 : gap_cnt_reg + 32'h0000_0001;
    on_cnt_reg  <= (!rst_n_i || !detect_o) ? 32'h0000_0000 : on_cnt_reg + 32'h0000_0001;
    // mode is taken once after release, as the design does; later strap moves are ignored
    if (!rst_n_i) begin
      lvl_reg <= 1'b0;
    end else if (!rst_q_reg) begin
      lvl_reg <= mode_strap_a_i;
    end
  end

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  property p_gap_flag; health_gap_pulse_o == !out_oe_o; endproperty
  a_gap_flag: assert property (p_gap_flag) else $error("gap flag differs from enable");
  property p_gap_len; $rose(out_oe_o) |-> gap_cnt_reg == GAP_CYC; endproperty
  a_gap_len: assert property (p_gap_len) else $error("gap length wrong");
  property p_req_after_gap; $rose(burst_req_o) |-> $rose(out_oe_o); endproperty
  a_req_after_gap: assert property (p_req_after_gap) else $error("burst without gap");
  property p_no_req_in_gap; !out_oe_o |-> !burst_req_o; endproperty
  a_no_req_in_gap: assert property (p_no_req_in_gap) else $error("burst request in gap");
  property p_req_drop; take |=> !burst_req_o; endproperty
  a_req_drop: assert property (p_req_drop) else $error("request held after result");
  property p_detect_cause; $rose(detect_o) |-> $past(take) || $past(take, 2); endproperty
  a_detect_cause: assert property (p_detect_cause) else $error("detect rose without burst");
  property p_maxon; on_cnt_reg <= MAXON_LONG_TICKS * TICK_CYC + TICK_CYC + 2; endproperty
  a_maxon: assert property (p_maxon) else $error("detection outlived max on");
  property p_level_on; lvl_reg && detect_o && $past(detect_o) |-> out_o == ACTIVE_HIGH; endproperty
  a_level_on: assert property (p_level_on) else $error("level output not active");
  property p_level_off; lvl_reg && !detect_o && !$past(detect_o) |-> out_o == !ACTIVE_HIGH; endproperty
  a_level_off: assert property (p_level_off) else $error("level output not idle");
endmodule : tdo_core_monitor

/* bench/tdo_front_model.sv */
// front-end model: answers each burst request with one count after a set latency.
// assumes the bench supplies the count and the latency; latency 1 is prompt, larger is slow.
`timescale 1ns/1ps
module tdo_front_model
  import tdo_pkg::*;
(
  input  wire logic             clk_i,
  input  wire logic             burst_req_i,
  input  wire logic [3:0]       lat_i,
  input  wire logic [SIG_W-1:0] level_i,
  output logic                  raw_valid_o,
  output logic [SIG_W-1:0]      raw_o
);
  logic [3:0] wait_reg;

  // one strobe per request: the strobe cycle itself blocks a second answer
  always_ff @(posedge clk_i) begin
    if (!burst_req_i || raw_valid_o) begin
      wait_reg    <= 4'h0;
      raw_valid_o <= 1'b0;
    end else begin
      wait_reg    <= wait_reg + 4'h1;
      raw_valid_o <= (wait_reg == lat_i);
    end
  end

  // off the strobe the count line shows a wrong value so stale data cannot pass
  assign raw_o = raw_valid_o ? level_i : ~level_i;
endmodule : tdo_front_model

/* bench/tdo_core_bench.sv */
// testbench of tdo_core: modes, integrator, burst spacing, max-on, gain and hysteresis.
// assumes shortened timing parameters and the front-end model on the burst link.
`timescale 1ns/1ps
`define check_eq(a, b) begin tests_run++; if ((a) !== (b)) begin failures++; \
  $display("unexpected at %0t: got %h expected %h", $time, (a), (b)); end end
module tdo_core_bench;
  import tdo_pkg::*;
  localparam int unsigned IDLE = 400, FAST = 200, TCK = 10, PUL = 50, SHORT = 20, LONG = 120;
  localparam logic        ACT  = 1'b0;
  localparam logic [15:0] BASE = 16'h1000;
  localparam logic [15:0] HI   = 16'h1100;
  logic        clk_i   = 1'b0;
  logic        rst_n_i = 1'b0;
  logic        strap_a = 1'b1;
  logic        strap_b = 1'b1;
  logic [1:0]  gain    = 2'h0;
  logic [3:0]  lat     = 4'h1;
  logic [15:0] level   = BASE;
  logic [15:0] raw;
  logic        raw_valid, burst_req, out, out_oe, gap, det;
  logic [1:0]  modes [4] = '{2'b11, 2'b10, 2'b00, 2'b01};
  int          failures = 0, tests_run = 0, act_cnt = 0, sp, base_cnt, dur, lim;

  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) if (out === ACT) act_cnt <= act_cnt + 1;

  tdo_core #(.ACTIVE_HIGH(ACT), .BURST_IDLE_CYC(IDLE), .BURST_FAST_CYC(FAST), .GAP_CYC(20),
    .PULSE_CYC(PUL), .TICK_CYC(TCK), .MAXON_SHORT_TICKS(SHORT), .MAXON_LONG_TICKS(LONG)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .mode_strap_a_i(strap_a), .mode_strap_b_i(strap_b),
    .gain_sel_i(gain), .raw_valid_i(raw_valid), .raw_i(raw), .burst_req_o(burst_req), .out_o(out),
    .out_oe_o(out_oe), .health_gap_pulse_o(gap), .detect_o(det));
  tdo_front_model u_front (.clk_i(clk_i), .burst_req_i(burst_req), .lat_i(lat), .level_i(level),
    .raw_valid_o(raw_valid), .raw_o(raw));

  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // power cycle: straps are steady before release and only read then
  task automatic restart(input logic a, input logic b, input logic [1:0] g);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    strap_a <= a;
    strap_b <= b;
    gain    <= g;
    level   <= BASE;
    repeat (20) @(posedge clk_i);
    rst_n_i <= 1'b1;
  endtask : restart

  // one burst reporting v; sp is the wait in cycles since the previous call
  task automatic burst(input logic [15:0] v);
    @(posedge clk_i);
    level <= v;
    sp = 0;
    do begin
      @(posedge clk_i);
      #1;
      sp++;
      if (sp > 2000) begin
        failures++;
        wrap_up();
      end
    end while (!(burst_req === 1'b1 && raw_valid === 1'b1));
    repeat (2) @(posedge clk_i);
    #1;
  endtask : burst

  task automatic hits(input logic [15:0] v, input int k);
    repeat (k) burst(v);
  endtask : hits

  initial begin
    for (int i = 0; i < 4; i++) begin
      restart(modes[i][1], modes[i][0], 2'h0);
      lat <= (i == 3) ? 4'h6 : 4'h1;
      lim = ((i == 1) ? LONG : SHORT) * TCK;
      burst(BASE);
      burst(BASE);
      `check_eq(sp inside {[IDLE - 8:IDLE + 16]}, 1'b1)
      hits(HI, 2);
      `check_eq(sp inside {[FAST - 8:FAST + 16]}, 1'b1)
      burst(HI);
      `check_eq(det, 1'b0)
      base_cnt = act_cnt;
      burst(HI);
      `check_eq(det, 1'b1)
      repeat (2) @(posedge clk_i);
      // toggle run moves the straps to level values; they must stay unread
      if (i == 2) begin
        strap_a <= 1'b1;
        strap_b <= 1'b1;
      end
      #1;
      `check_eq(out, ACT)
      dur = 0;
      while (det === 1'b1 && dur < 3000) begin
        @(posedge clk_i);
        #1;
        dur++;
      end
      if (dur >= 3000) begin
        failures++;
        wrap_up();
      end
      `check_eq(dur + TCK + 4 >= lim && dur <= lim + TCK, 1'b1)
      // in level mode the output register follows detect_o one cycle later; toggle mode keeps its latched state
      @(posedge clk_i);
      #1;
      `check_eq(out, (i == 2) ? ACT : ~ACT)
      if (i == 3) `check_eq(act_cnt - base_cnt, PUL)
      hits(HI, 5);
      `check_eq(det, 1'b0)
    end
    for (int g = 0; g < 4; g++) begin
      restart(1'b1, 1'b0, g[1:0]);
      burst(BASE);
      if (g == 3) begin
        hits(HI, 2);
        burst(BASE);
        hits(HI, 3);
        `check_eq(det, 1'b0)
      end
      hits(HI, (g == 3) ? 1 : 4);
      `check_eq(det, (g == 0 || g == 3))
      if (g == 0) begin
        burst(16'h1050);
        `check_eq(det, 1'b1)
        burst(16'h1030);
        `check_eq(det, 1'b0)
        `check_eq(out, ~ACT)
      end
    end
    wrap_up();
  end
endmodule : tdo_core_bench

bind tdo_core tdo_core_monitor #(.ACTIVE_HIGH(ACTIVE_HIGH), .GAP_CYC(GAP_CYC), .TICK_CYC(TICK_CYC),
  .MAXON_LONG_TICKS(MAXON_LONG_TICKS)) u_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i),
  .mode_strap_a_i(mode_strap_a_i), .raw_valid_i(raw_valid_i), .burst_req_o(burst_req_o), .out_o(out_o),
  .out_oe_o(out_oe_o), .health_gap_pulse_o(health_gap_pulse_o), .detect_o(detect_o));
